// *** shared/pts_pkg.sv ***
package pts_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS          = 50;
    localparam int SEC_NS          = 1000000000;
    localparam int DEF_CYC_PER_SEC = SEC_NS / CLK_NS;
    localparam int TOL_NS          = 1000000;
    localparam int DEF_TOL_CYC     = TOL_NS / CLK_NS;
    localparam int PULSE_NS        = 100000000;
    localparam int DEF_PULSE_CYC   = PULSE_NS / CLK_NS;
    localparam int DEF_SYNTH_HZ    = SEC_NS / CLK_NS;
    localparam logic [3:0] FAIL_SECS   = 4'ha;
    localparam logic [3:0] RELOAD_SECS = 4'ha;
    localparam int HOST_STEP_S     = 1;

    // ------------------------------------------------------------
    // Threshold defaults in ns
    // ------------------------------------------------------------
    localparam logic [31:0] THR_SERIAL_NS    = 32'h0000_0254;
    localparam logic [31:0] THR_HOST_UNIX_NS = 32'h0000_2ee0;
    localparam logic [31:0] THR_HOST_WIN_NS  = 32'h0000_c350;

    // ------------------------------------------------------------
    // Register offsets and control fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_THRESH   = 8'h04;
    localparam logic [7:0] OFS_HOST_SEC = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_FAILS    = 8'h10;
    localparam logic [7:0] OFS_RESYNCS  = 8'h14;
    localparam logic [7:0] OFS_FREQ     = 8'h18;
    localparam logic [7:0] OFS_PHASE    = 8'h1c;
    localparam logic [7:0] OFS_WFREQ    = 8'h20;
    localparam logic [7:0] OFS_WPHASE   = 8'h24;
    localparam logic [7:0] OFS_XTAL     = 8'h28;
    localparam logic [7:0] OFS_SYNTH    = 8'h2c;
    localparam logic [7:0] OFS_TOTAL    = 8'h30;
    localparam logic [7:0] OFS_BAD      = 8'h34;
    localparam logic [7:0] OFS_SINGLES  = 8'h38;
    localparam logic [7:0] OFS_LONGEST  = 8'h3c;
    localparam logic [7:0] OFS_LAT_SEC  = 8'h40;
    localparam logic [7:0] OFS_LAT_FRAC = 8'h44;
    localparam logic [7:0] OFS_CUR_SEC  = 8'h48;
    localparam int CTRL_IN_LSB  = 0;
    localparam int CTRL_OUT_LSB = 2;
    localparam int CTRL_EN_BIT  = 5;
    localparam int CTRL_WIN_BIT = 6;
    localparam int CTRL_CLR_BIT = 8;
    localparam int CTRL_SET_BIT = 9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IN_DIFF_SERIAL = 2'b00, IN_HOST = 2'b01, IN_OVERFLOW = 2'b10, IN_AUX = 2'b11
    } pts_in_sel_t;
    typedef enum logic [2:0] {
        OUT_NONE = 3'b000, OUT_SERIAL_REPEAT = 3'b001, OUT_HOST = 3'b010,
        OUT_MASTER = 3'b011, OUT_LOOP = 3'b100
    } pts_out_sel_t;
    typedef enum logic [1:0] {ST_FREE = 2'b00, ST_SYNC = 2'b01, ST_LOST = 2'b10} pts_sync_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pts_bus_t;

    typedef struct packed {
        logic [1:0]   s1;
        logic [1:0]   s2;
        logic         sel_d;
        logic [24:0]  frac;
        logic [31:0]  sec;
        logic [24:0]  ivl_sub;
        logic [7:0]   ivl_sec;
        logic         seen;
        pts_sync_t    st;
        logic [3:0]   above;
        logic [3:0]   lost;
        pts_in_sel_t  in_sel;
        pts_out_sel_t out_sel;
        logic         sync_en;
        logic         host_win;
        logic         ever;
        logic         pps_out;
        logic [31:0]  thresh;
        logic [31:0]  host_sec;
        logic [31:0]  fails;
        logic [31:0]  resyncs;
        logic [31:0]  freq;
        logic [31:0]  phase;
        logic [31:0]  wfreq;
        logic [31:0]  wphase;
        logic [31:0]  xtal;
        logic [31:0]  total;
        logic [31:0]  bad;
        logic [31:0]  singles;
        logic [31:0]  longest;
        logic [31:0]  lat_sec;
        logic [31:0]  lat_frac;
        logic [31:0]  rdata;
    } pts_state_t;

    localparam pts_state_t PTS_RESET = '{thresh: THR_SERIAL_NS, in_sel: IN_DIFF_SERIAL, out_sel: OUT_NONE,
                                         st: ST_FREE, default: '0};
endpackage : pts_pkg

// *** src/pts_monitor.sv ***
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module pts_monitor
    import pts_pkg::*;
#(
    parameter int CYC_PER_SEC = DEF_CYC_PER_SEC,
    parameter int TOL_CYC     = DEF_TOL_CYC,
    parameter int PULSE_CYC   = DEF_PULSE_CYC,
    parameter int SYNTH_HZ    = DEF_SYNTH_HZ
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire pts_bus_t    BUS,
    input  wire logic        SERIAL_PPS_IN,
    input  wire logic        AUX_PPS_IN,
    input  wire logic        HOST_PPS,
    output logic [31:0]      RD_DATA,
    output logic             PPS_OUT,
    output logic             SYNCED,
    output logic             FREE_RUN
);
    localparam logic [24:0] CYC      = 25'(CYC_PER_SEC);
    localparam logic [24:0] CYC_LAST = 25'(CYC_PER_SEC - 1);
    localparam logic [24:0] HALF     = 25'(CYC_PER_SEC / 2);
    localparam logic [24:0] TOL      = 25'(TOL_CYC);
    localparam logic [24:0] PW       = 25'(PULSE_CYC);
    localparam int          PPB_STEP = SEC_NS / CYC_PER_SEC;

    pts_state_t s;
    pts_state_t next_s;
    logic       acc;
    logic       clr;
    logic       pedge;
    logic       lvl;

    assign RD_DATA  = s.rdata;
    assign PPS_OUT  = s.pps_out;
    assign SYNCED   = s.st == ST_SYNC;
    assign FREE_RUN = !s.ever;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic               tick;
        logic               near_lo;
        logic               near_hi;
        logic               reload;
        logic               wr_ctrl;
        logic [7:0]         k;
        logic signed [25:0] dev;
        logic signed [25:0] ph;
        logic signed [31:0] ph_ns;
        logic signed [31:0] fr_ppb;
        logic signed [31:0] diff;
        logic [31:0]        ph_abs;
        logic [31:0]        fr_abs;
        tick    = s.frac == CYC_LAST;
        wr_ctrl = BUS.wr && BUS.addr == OFS_CTRL;
        near_lo = 1'b0;
        near_hi = 1'b0;
        reload  = 1'b0;
        k       = '0;
        dev     = '0;
        ph      = '0;
        ph_ns   = '0;
        fr_ppb  = '0;
        diff    = '0;
        ph_abs  = '0;
        fr_abs  = '0;
        next_s  = s;
        acc     = 1'b0;
        // Two flops per serial and aux pin; edge logic uses their second stage, but HOST_PPS is taken unsynchronized
        next_s.s1 = {AUX_PPS_IN, SERIAL_PPS_IN};
        next_s.s2 = s.s1;
        case (s.in_sel)
            IN_DIFF_SERIAL: lvl = s.s2[0];
            IN_HOST:        lvl = HOST_PPS;
            IN_OVERFLOW:    lvl = s.frac < PW;
            IN_AUX:         lvl = s.s2[1];
            default:        lvl = 1'b0;
        endcase
        pedge        = lvl & ~s.sel_d;
        next_s.sel_d = lvl;

        // ------------------------------------------------------------
        // Register writes and commands
        // ------------------------------------------------------------
        clr     = wr_ctrl && (BUS.wdata[CTRL_CLR_BIT] || BUS.wdata[CTRL_SET_BIT]);
        if (wr_ctrl) begin
            next_s.in_sel   = pts_in_sel_t'(BUS.wdata[CTRL_IN_LSB +: 2]);
            next_s.out_sel  = pts_out_sel_t'(BUS.wdata[CTRL_OUT_LSB +: 3]);
            next_s.sync_en  = BUS.wdata[CTRL_EN_BIT];
            next_s.host_win = BUS.wdata[CTRL_WIN_BIT];
            if (BUS.wdata[CTRL_IN_LSB +: 2] == IN_DIFF_SERIAL) begin
                next_s.thresh = THR_SERIAL_NS;
            end else if (BUS.wdata[CTRL_WIN_BIT]) begin
                next_s.thresh = THR_HOST_WIN_NS;
            end else begin
                next_s.thresh = THR_HOST_UNIX_NS;
            end
        end else if (BUS.wr && BUS.addr == OFS_THRESH) begin
            next_s.thresh = BUS.wdata;
        end else if (BUS.wr && BUS.addr == OFS_HOST_SEC) begin
            next_s.host_sec = BUS.wdata;
        end
        // Clearing first lets an event in the same cycle still count
        if (clr) begin
            next_s.fails   = '0;
            next_s.resyncs = '0;
            next_s.freq    = '0;
            next_s.phase   = '0;
            next_s.wfreq   = '0;
            next_s.wphase  = '0;
            next_s.total   = '0;
            next_s.bad     = '0;
            next_s.singles = '0;
            next_s.longest = '0;
        end

        // ------------------------------------------------------------
        // Own clock and interval timer
        // ------------------------------------------------------------
        next_s.frac = tick ? '0 : s.frac + 25'h1;
        if (tick) begin
            next_s.sec = s.sec + 32'h1;
            diff       = $signed(s.sec - next_s.host_sec);
            if (s.sync_en && (diff > HOST_STEP_S || diff < -HOST_STEP_S)) begin
                next_s.resyncs = next_s.resyncs + 32'h1;
                reload         = 1'b1;
            end
            if (s.st == ST_LOST) begin
                if (s.lost == RELOAD_SECS) begin
                    reload = 1'b1;
                end else begin
                    next_s.lost = s.lost + 4'h1;
                end
            end
        end
        if (s.ivl_sub == CYC_LAST) begin
            next_s.ivl_sub = '0;
            next_s.ivl_sec = (s.ivl_sec == 8'hff) ? s.ivl_sec : s.ivl_sec + 8'h1;
        end else begin
            next_s.ivl_sub = s.ivl_sub + 25'h1;
        end

        // ------------------------------------------------------------
        // Pulse measurement
        // ------------------------------------------------------------
        ph     = (s.frac < HALF) ? $signed({1'b0, s.frac}) : $signed({1'b0, s.frac}) - $signed({1'b0, CYC});
        ph_ns  = 32'(ph * CLK_NS);
        ph_abs = ph_ns[31] ? 32'(-ph_ns) : 32'(ph_ns);
        if (pedge) begin
            next_s.total = next_s.total + 32'h1;
            near_lo      = s.ivl_sub <= TOL;
            near_hi      = s.ivl_sub >= CYC - TOL;
            k            = near_lo ? s.ivl_sec : s.ivl_sec + 8'h1;
            if (!s.seen || ((near_lo || near_hi) && k != 8'h0)) begin
                acc = 1'b1;
            end else begin
                next_s.bad = next_s.bad + 32'h1;
            end
        end
        if (acc) begin
            next_s.seen     = 1'b1;
            next_s.ivl_sub  = 25'h1;
            next_s.ivl_sec  = '0;
            next_s.lat_sec  = s.sec;
            next_s.lat_frac = 32'(s.frac);
            next_s.phase    = 32'(ph_ns);
            if (ph_abs > next_s.wphase) begin
                next_s.wphase = ph_abs;
            end
            // Edge cycle is count zero, so a perfect reference reads zero phase and frequency error
            next_s.frac = 25'h1;
            next_s.sec  = (s.frac < HALF) ? s.sec : s.sec + 32'h1;
            if (s.seen) begin
                if (k == 8'h2) begin
                    next_s.singles = next_s.singles + 32'h1;
                end
                if (32'(k) > next_s.longest) begin
                    next_s.longest = 32'(k);
                end
                if (k == 8'h1) begin
                    dev    = near_lo ? $signed({1'b0, s.ivl_sub}) : $signed({1'b0, s.ivl_sub}) - $signed({1'b0, CYC});
                    fr_ppb = 32'(dev * PPB_STEP);
                    fr_abs = fr_ppb[31] ? 32'(-fr_ppb) : 32'(fr_ppb);
                    next_s.freq = 32'(fr_ppb);
                    next_s.xtal = 32'($signed({7'h0, CYC}) + 32'(dev));
                    if (fr_abs > next_s.wfreq) begin
                        next_s.wfreq = fr_abs;
                    end
                end
            end
            if (ph_abs > s.thresh) begin
                if (s.above == FAIL_SECS - 4'h1) begin
                    next_s.st = ST_LOST;
                    if (s.st == ST_SYNC) begin
                        next_s.fails = next_s.fails + 32'h1;
                    end
                end else if (s.st != ST_LOST) begin
                    next_s.above = s.above + 4'h1;
                end
            end else begin
                next_s.above = '0;
                next_s.lost  = '0;
                next_s.st    = ST_SYNC;
                next_s.ever  = 1'b1;
            end
        end
        if (reload || (wr_ctrl && BUS.wdata[CTRL_SET_BIT])) begin
            next_s.sec   = next_s.host_sec;
            next_s.frac  = '0;
            next_s.seen  = 1'b0;
            next_s.st    = ST_FREE;
            next_s.above = '0;
            next_s.lost  = '0;
        end

        // ------------------------------------------------------------
        // Pulse output
        // ------------------------------------------------------------
        case (s.out_sel)
            OUT_SERIAL_REPEAT: next_s.pps_out = s.s2[0];
            OUT_HOST:          next_s.pps_out = HOST_PPS;
            OUT_MASTER:        next_s.pps_out = s.frac < PW;
            OUT_LOOP:          next_s.pps_out = lvl;
            default:           next_s.pps_out = 1'b0;
        endcase

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        next_s.rdata = '0;
        if (BUS.rd) begin
            if (BUS.addr == OFS_CTRL) begin
                next_s.rdata = {25'h0, s.host_win, s.sync_en, s.out_sel, s.in_sel};
            end else if (BUS.addr == OFS_THRESH) begin
                next_s.rdata = s.thresh;
            end else if (BUS.addr == OFS_HOST_SEC) begin
                next_s.rdata = s.host_sec;
            end else if (BUS.addr == OFS_STATUS) begin
                next_s.rdata = {25'h0, s.lost[2:0], !s.ever, s.seen, s.st};
            end else if (BUS.addr == OFS_FAILS) begin
                next_s.rdata = s.fails;
            end else if (BUS.addr == OFS_RESYNCS) begin
                next_s.rdata = s.resyncs;
            end else if (BUS.addr == OFS_FREQ) begin
                next_s.rdata = s.freq;
            end else if (BUS.addr == OFS_PHASE) begin
                next_s.rdata = s.phase;
            end else if (BUS.addr == OFS_WFREQ) begin
                next_s.rdata = s.wfreq;
            end else if (BUS.addr == OFS_WPHASE) begin
                next_s.rdata = s.wphase;
            end else if (BUS.addr == OFS_XTAL) begin
                next_s.rdata = s.xtal;
            end else if (BUS.addr == OFS_SYNTH) begin
                next_s.rdata = 32'(SYNTH_HZ);
            end else if (BUS.addr == OFS_TOTAL) begin
                next_s.rdata = s.total;
            end else if (BUS.addr == OFS_BAD) begin
                next_s.rdata = s.bad;
            end else if (BUS.addr == OFS_SINGLES) begin
                next_s.rdata = s.singles;
            end else if (BUS.addr == OFS_LONGEST) begin
                next_s.rdata = s.longest;
            end else if (BUS.addr == OFS_LAT_SEC) begin
                next_s.rdata = s.lat_sec;
            end else if (BUS.addr == OFS_LAT_FRAC) begin
                next_s.rdata = s.lat_frac;
            end else if (BUS.addr == OFS_CUR_SEC) begin
                next_s.rdata = s.sec;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s <= PTS_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    AST_INPUT_SELECT: assert property (BUS.wr && BUS.addr == OFS_CTRL |=> s.in_sel == $past(BUS.wdata[1:0]))
        else $error("input select not taken from control write");
    AST_LOOP_OUT: assert property (s.out_sel == OUT_LOOP && $stable(s.out_sel) |=> PPS_OUT == $past(lvl))
        else $error("loop output does not follow selected input");
    AST_LOST_AFTER_TEN: assert property ($past(s.st) != ST_LOST && s.st == ST_LOST |-> $past(s.above) == 4'h9)
        else $error("lost state entered without nine prior bad pulses");
    AST_THRESH_SERIAL: assert property (BUS.wr && BUS.addr == OFS_CTRL && BUS.wdata[1:0] == 2'b00
                                        |=> s.thresh == THR_SERIAL_NS)
        else $error("serial threshold default not loaded");
    AST_FAIL_COUNT: assert property (s.st == ST_SYNC && acc && !clr ##1 s.st == ST_LOST
                                     |-> s.fails == $past(s.fails) + 32'h1)
        else $error("failure not counted");
    AST_TOTAL_COUNT: assert property (pedge && !clr |=> s.total == $past(s.total) + 32'h1)
        else $error("received pulse not counted");
    AST_LATCH_TIME: assert property (acc && !(BUS.wr && BUS.addr == OFS_CTRL)
                                     |=> s.lat_sec == $past(s.sec) && (s.frac == 25'h1 || !s.seen))
        else $error("time not latched on accepted pulse");
    AST_CLEAR_STATS: assert property (clr && !pedge |=> s.total == 32'h0 && s.bad == 32'h0 && s.wphase == 32'h0)
        else $error("statistics not cleared");
    AST_READ_ONE_CYCLE: assert property (!BUS.rd |=> RD_DATA == 32'h0)
        else $error("read data outside read answer cycle");
    AST_WORST_PHASE: assert property (acc && !clr |=> s.wphase >= $past(s.wphase))
        else $error("worst phase decreased without clear");

    COV_ACCEPT: cover property (acc ##[1:1000] acc);
    COV_LOST: cover property (s.st == ST_SYNC ##1 s.st == ST_LOST);
    COV_SINGLE: cover property ($changed(s.singles) && !clr);
    COV_BAD: cover property ($changed(s.bad) && !clr);
endmodule : pts_monitor

// *** sim/pts_pulse_ref.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Reference pulse source
// ----------------------------------------
// Period changes stand in for noise and dropped pulses from the far end
module pts_pulse_ref (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        en,
    input  wire logic [15:0] period,
    output logic             pps
);
    logic [15:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
            pps <= 1'b0;
        end else begin
            cnt <= (!en || cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
            pps <= en && cnt < 16'h0004;
        end
    end
endmodule : pts_pulse_ref

// *** sim/pts_monitor_bench.sv ***
`timescale 1ns/1ps
module pts_monitor_bench
    import pts_pkg::*;
;
    localparam int CPS = 200;
    localparam int PCYC = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    pts_bus_t    bus = '0;
    logic        host_pps = 1'b0;
    logic        aux_pps = 1'b0;
    logic        ref_en = 1'b0;
    logic [15:0] ref_period = 16'h00c8;
    logic        ref_pps;
    logic [31:0] rd_data;
    logic        pps_out;
    logic        synced;
    logic        free_run;
    logic [31:0] v;
    int          errors = 0;
    int          checks = 0;
    int          n;
    logic [7:0]  stat_ofs[9] = '{OFS_TOTAL, OFS_BAD, OFS_SINGLES, OFS_LONGEST, OFS_WFREQ, OFS_WPHASE,
                                 OFS_FAILS, OFS_FREQ, OFS_PHASE};

    always #25 clk = ~clk;

    pts_pulse_ref u_pts_pulse_ref (.clk(clk), .rst(rst), .en(ref_en), .period(ref_period), .pps(ref_pps));
    pts_monitor #(.CYC_PER_SEC(CPS), .TOL_CYC(10), .PULSE_CYC(PCYC)) u_pts_monitor (
        .CLK(clk), .RST(rst), .BUS(bus), .SERIAL_PPS_IN(ref_pps), .AUX_PPS_IN(aux_pps),
        .HOST_PPS(host_pps), .RD_DATA(rd_data), .PPS_OUT(pps_out), .SYNCED(synced), .FREE_RUN(free_run));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Leading edge keeps a release and the next request out of one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 v = rd_data;
    endtask : rd
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, v);
    endtask : rdchk
    // Skips any pulse in progress so only a whole pulse is measured
    task automatic width(output int w);
        w = 0;
        #1;
        for (int i = 0; i < 2 * CPS && pps_out !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        for (int i = 0; i < 2 * CPS && pps_out !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        for (int i = 0; i < 2 * CPS && pps_out === 1'b1; i++) begin
            @(posedge clk);
            #1;
            w++;
        end
    endtask : width
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("free_run", 32'h1, 32'(free_run));
        rdchk("thresh", OFS_THRESH, THR_SERIAL_NS);
        rdchk("synth", OFS_SYNTH, DEF_SYNTH_HZ);
        rdchk("unmapped", 8'hfc, 32'h0);
        wr(OFS_CTRL, 32'h0000_0001);
        rdchk("thresh_host", OFS_THRESH, THR_HOST_UNIX_NS);
        wr(OFS_CTRL, 32'h0000_0041);
        rdchk("thresh_win", OFS_THRESH, THR_HOST_WIN_NS);
        wr(OFS_THRESH, 32'h0000_04d2);
        rdchk("thresh_prog", OFS_THRESH, 32'h0000_04d2);
        wr(OFS_CTRL, 32'h0000_0109);
        host_pps <= 1'b1;
        @(posedge clk);
        #1 chk("out_host", 32'h1, 32'(pps_out));
        @(posedge clk);
        host_pps <= 1'b0;
        rdchk("total_host", OFS_TOTAL, 32'h1);
        wr(OFS_CTRL, 32'h0000_0113);
        aux_pps <= 1'b1;
        for (int i = 0; i < 8 && pps_out !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("out_loop", 32'h1, 32'(pps_out));
        @(posedge clk);
        aux_pps <= 1'b0;
        rdchk("total_aux", OFS_TOTAL, 32'h1);
        wr(OFS_CTRL, 32'h0000_010e);
        repeat (CPS + 50) @(posedge clk);
        rd(OFS_TOTAL);
        chk("total_ovf", 32'h1, 32'(v != 32'h0));
        width(n);
        chk("master_width", 32'(PCYC), 32'(n));
        // Reference pulses on the serial pin at exactly one second
        wr(OFS_HOST_SEC, 32'h0000_0064);
        wr(OFS_CTRL, 32'h0000_0304);
        rdchk("set_time", OFS_CUR_SEC, 32'h0000_0064);
        ref_en <= 1'b1;
        repeat (6 * CPS) @(posedge clk);
        #1 chk("synced", 32'h1, 32'(synced));
        chk("free_run_off", 32'h0, 32'(free_run));
        rdchk("bad_none", OFS_BAD, 32'h0);
        rdchk("longest_1", OFS_LONGEST, 32'h1);
        rd(OFS_PHASE);
        chk("phase", 32'h1, 32'($signed(v) <= 596 && $signed(v) >= -596));
        width(n);
        chk("out_repeat", 32'h4, 32'(n));
        // Slow reference drifts past a tight threshold every pulse
        wr(OFS_HOST_SEC, 32'h0000_01f4);
        wr(OFS_THRESH, 32'h0000_003c);
        ref_period <= 16'h00cb;
        repeat (13 * CPS) @(posedge clk);
        #1 chk("lost", 32'h0, 32'(synced));
        rdchk("fails", OFS_FAILS, 32'h1);
        rdchk("freq", OFS_FREQ, 32'((203 - CPS) * (SEC_NS / CPS)));
        rdchk("xtal", OFS_XTAL, 32'h0000_00cb);
        rdchk("phase_late", OFS_PHASE, 32'h0000_0096);
        ref_en <= 1'b0;
        repeat (12 * CPS) @(posedge clk);
        rd(OFS_CUR_SEC);
        chk("reload", 32'h1, 32'(v >= 32'h01f4 && v <= 32'h01fa));
        wr(OFS_THRESH, THR_SERIAL_NS);
        ref_period <= 16'h0190;
        ref_en <= 1'b1;
        repeat (7 * CPS) @(posedge clk);
        rdchk("longest_2", OFS_LONGEST, 32'h2);
        rd(OFS_SINGLES);
        chk("singles", 32'h1, 32'(v != 32'h0));
        ref_period <= 16'h0064;
        repeat (4 * CPS) @(posedge clk);
        rd(OFS_BAD);
        chk("bad", 32'h1, 32'(v != 32'h0));
        ref_en <= 1'b0;
        repeat (8) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0104);
        foreach (stat_ofs[i]) rdchk("cleared", stat_ofs[i], 32'h0);
        // Host seconds far from card time force one reload
        wr(OFS_HOST_SEC, 32'h0000_0384);
        wr(OFS_CTRL, 32'h0000_0020);
        repeat (CPS + 50) @(posedge clk);
        rdchk("resyncs", OFS_RESYNCS, 32'h1);
        rd(OFS_CUR_SEC);
        chk("host_sec", 32'h1, 32'(v >= 32'h0384 && v <= 32'h0385));
        results();
    end
endmodule : pts_monitor_bench
